// *** hdl/pwm_pkg.sv ***
// package for the ten-bit pwm channel: register map, fields, reset values
package pwm_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_DUTY_LOW = 4'h0;
  localparam logic [3:0] ADDR_DUTY_ACTIVE = 4'h1;
  localparam logic [3:0] ADDR_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_TIMEBASE_SEL = 4'h3;
  localparam logic [3:0] ADDR_LIMIT_A = 4'h4;
  localparam logic [3:0] ADDR_LIMIT_B = 4'h5;
  localparam logic [3:0] ADDR_TIMER_CTRL_A = 4'h6;
  localparam logic [3:0] ADDR_TIMER_CTRL_B = 4'h7;
  localparam logic [3:0] ADDR_TIMER_A = 4'h8;
  localparam logic [3:0] ADDR_TIMER_B = 4'h9;
  localparam int CTRL_EXT_LSB = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h3F;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam int TSEL_BIT = 3;
  localparam int TCTRL_ON_BIT = 2;
  localparam logic [7:0] TCTRL_WMASK = 8'h7F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'hFF;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam int QCLK_PHASES = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] count;
    logic [1:0] sub;
    logic tick;
    logic wrap;
  } timebase_t;
endpackage

// *** hdl/pwm_channel.sv ***
// ten-bit pwm channel with two selectable period timers and register port
`timescale 1ns/100ps
module pwm_channel (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [pwm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_pin_direction_bit,
  output logic [7:0] o_rdata,
  output logic o_channel_output_pin,
  output logic o_channel_output_oe
);
  import pwm_pkg::*;

  bus_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  logic [7:0] duty_low_reg_r;
  logic [7:0] duty_active_reg_r;
  logic [1:0] duty_ext_latch_r;
  logic [7:0] channel_control_reg_r;
  logic [7:0] timebase_select_reg_r;
  logic [7:0] period_limit_r [2];
  logic [7:0] timer_ctrl_r [2];
  logic [7:0] rdata_r;
  logic pin_r;
  timebase_t tb [2];

  wire wr_duty_low = req.wr && (req.addr == ADDR_DUTY_LOW);
  wire wr_duty_active = req.wr && (req.addr == ADDR_DUTY_ACTIVE);
  wire wr_control = req.wr && (req.addr == ADDR_CONTROL);
  wire wr_tsel = req.wr && (req.addr == ADDR_TIMEBASE_SEL);
  wire [1:0] mode_hi = channel_control_reg_r[CTRL_MODE_LSB+2 +: 2];
  wire pwm_mode = (mode_hi == MODE_PWM);
  wire channel_off = (channel_control_reg_r[CTRL_MODE_LSB +: 4] == RST_MODE);

  // per timer: prescaler, quadrature sub-count, 8-bit count, limit compare
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_timer
      logic [3:0] pre_r;
      logic [1:0] sub_r;
      logic [7:0] count_r;
      logic [3:0] pre_top;
      wire wr_limit = req.wr && (req.addr == (g == 0 ? ADDR_LIMIT_A : ADDR_LIMIT_B));
      wire wr_tctrl = req.wr && (req.addr == (g == 0 ? ADDR_TIMER_CTRL_A : ADDR_TIMER_CTRL_B));
      wire wr_count = req.wr && (req.addr == (g == 0 ? ADDR_TIMER_A : ADDR_TIMER_B));
      wire running = timer_ctrl_r[g][TCTRL_ON_BIT];
      wire [1:0] ps = timer_ctrl_r[g][1:0];
      // postscaler bits 6:3 are stored only; they never reach the period logic
      assign pre_top = (ps == PRE_DIV1) ? 4'h0 : (ps == PRE_DIV4) ? 4'h3 : 4'hF;
      wire pre_done = running && (pre_r == pre_top);
      wire sub_done = pre_done && (sub_r == 2'(QCLK_PHASES - 1));
      wire at_limit = (count_r == period_limit_r[g]);
      // the two low time-base bits step once per prescale period, so one base step
      // is always prescale clocks long whatever the ratio
      wire [1:0] sub_bits = sub_r;

      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          pre_r <= 4'h0;
          sub_r <= 2'h0;
          count_r <= RST_BYTE;
          period_limit_r[g] <= RST_LIMIT;
          timer_ctrl_r[g] <= RST_BYTE;
        end else begin
          if (wr_limit) begin
            period_limit_r[g] <= req.wdata;
          end
          if (wr_tctrl) begin
            timer_ctrl_r[g] <= req.wdata & TCTRL_WMASK;
          end
          if (wr_tctrl || wr_count) begin
            pre_r <= 4'h0;
            sub_r <= 2'h0;
          end else if (running) begin
            pre_r <= pre_done ? 4'h0 : pre_r + 4'h1;
            if (pre_done) begin
              sub_r <= sub_r + 2'h1;
            end
          end
          if (wr_count) begin
            count_r <= req.wdata;
          end else if (sub_done) begin
            count_r <= at_limit ? RST_BYTE : count_r + 8'h01;
          end
        end
      end

      // tick marks every step of the ten-bit base, wrap the last step of a period
      assign tb[g] = '{count: count_r, sub: sub_bits,
                       tick: pre_done, wrap: sub_done && at_limit};
    end
  endgenerate

  wire sel_b = timebase_select_reg_r[TSEL_BIT];
  timebase_t tsel;
  assign tsel = sel_b ? tb[1] : tb[0];
  wire [9:0] timebase = {tsel.count, tsel.sub};
  wire [9:0] duty_written = {duty_low_reg_r, channel_control_reg_r[CTRL_EXT_LSB +: 2]};
  wire [9:0] duty_active = {duty_active_reg_r, duty_ext_latch_r};
  wire period_start = pwm_mode && tsel.wrap;
  // match on the base value about to be entered, so the registered pin falls in
  // the very cycle the base equals the duty; above the period it never comes
  wire [9:0] base_next = timebase + 10'h001;
  wire duty_match = (duty_active == base_next);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      duty_low_reg_r <= RST_BYTE;
      duty_active_reg_r <= RST_BYTE;
      duty_ext_latch_r <= 2'h0;
      channel_control_reg_r <= RST_BYTE;
      timebase_select_reg_r <= RST_BYTE;
    end else begin
      if (wr_duty_low) begin
        duty_low_reg_r <= req.wdata;
      end
      if (wr_control) begin
        channel_control_reg_r <= req.wdata & CTRL_WMASK;
      end
      if (wr_tsel) begin
        timebase_select_reg_r <= req.wdata & 8'h1F;
      end
      if (period_start) begin
        duty_active_reg_r <= duty_low_reg_r;
        duty_ext_latch_r <= channel_control_reg_r[CTRL_EXT_LSB +: 2];
      end else if (wr_duty_active && !pwm_mode) begin
        duty_active_reg_r <= req.wdata;
      end
    end
  end

  // output latch; zero control clears it but the port latch is untouched
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pin_r <= 1'b0;
    end else if (wr_control && (req.wdata == RST_BYTE)) begin
      pin_r <= 1'b0;
    end else if (channel_off || !pwm_mode) begin
      pin_r <= 1'b0;
    end else if (period_start) begin
      pin_r <= (duty_written != 10'h000);
    end else if (tsel.tick && duty_match) begin
      pin_r <= 1'b0;
    end
  end

  wire [7:0] rd_mux =
    (req.addr == ADDR_DUTY_LOW) ? duty_low_reg_r :
    (req.addr == ADDR_DUTY_ACTIVE) ? duty_active_reg_r :
    (req.addr == ADDR_CONTROL) ? channel_control_reg_r :
    (req.addr == ADDR_TIMEBASE_SEL) ? timebase_select_reg_r :
    (req.addr == ADDR_LIMIT_A) ? period_limit_r[0] :
    (req.addr == ADDR_LIMIT_B) ? period_limit_r[1] :
    (req.addr == ADDR_TIMER_CTRL_A) ? timer_ctrl_r[0] :
    (req.addr == ADDR_TIMER_CTRL_B) ? timer_ctrl_r[1] :
    (req.addr == ADDR_TIMER_A) ? tb[0].count :
    (req.addr == ADDR_TIMER_B) ? tb[1].count : RST_BYTE;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_r <= RST_BYTE;
    end else begin
      rdata_r <= req.rd ? rd_mux : RST_BYTE;
    end
  end

  assign o_rdata = rdata_r;
  assign o_channel_output_pin = pin_r;
  // pin drives only when software made it an output (direction bit low)
  assign o_channel_output_oe = !i_pin_direction_bit;
endmodule

// *** dv/pwm_checker.sv ***
// port assertions for the ten-bit pwm channel
`timescale 1ns/100ps
module pwm_checker
  import pwm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_pin_direction_bit,
  input wire logic [7:0] o_rdata,
  input wire logic o_channel_output_pin,
  input wire logic o_channel_output_oe
);
  logic [7:0] ctrl_s;
  logic [7:0] tsel_s;
  logic [1:0] mode_h;
  logic mode_ok;
  assign mode_ok = ctrl_s[3:2] == MODE_PWM;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_s <= RST_BYTE;
      tsel_s <= RST_BYTE;
      mode_h <= 2'h0;
    end else begin
      mode_h <= {mode_h[0], mode_ok};
      if (i_wr && i_addr == ADDR_CONTROL) ctrl_s <= i_wdata & CTRL_WMASK;
      if (i_wr && i_addr == ADDR_TIMEBASE_SEL) tsel_s <= i_wdata & 8'h1F;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_oe_follows_dir: assert property (o_channel_output_oe == !i_pin_direction_bit)
    else $error("oe wrong");
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("rdata not idle");
  a_ctrl_readback: assert property (i_rd && i_addr == ADDR_CONTROL |=> o_rdata == $past(ctrl_s))
    else $error("control readback");
  a_tsel_readback: assert property (i_rd && i_addr == ADDR_TIMEBASE_SEL |=> o_rdata == $past(tsel_s))
    else $error("select readback");
  a_unmapped_zero: assert property (i_rd && i_addr > ADDR_TIMER_B |=> o_rdata == 8'h00)
    else $error("unmapped read");
  a_ctrl_zero_low: assert property (i_wr && i_addr == ADDR_CONTROL && i_wdata == 8'h00 |-> ##2 !o_channel_output_pin)
    else $error("pin not forced low");
  a_nonpwm_pin_low: assert property (!mode_ok && mode_h == 2'h0 |-> !o_channel_output_pin)
    else $error("pin high outside pwm");
  a_rise_in_pwm: assert property ($rose(o_channel_output_pin) |-> mode_h[0])
    else $error("rise outside pwm");
endmodule
bind pwm_channel pwm_checker i_pwm_checker (.i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_pin_direction_bit, .o_rdata, .o_channel_output_pin, .o_channel_output_oe);

// *** dv/pwm_load.sv ***
// load on the pwm pin: measures high time and period in clocks
`timescale 1ns/100ps
module pwm_load (
  input wire logic i_clock,
  input wire logic i_pin,
  input wire logic i_oe,
  output logic [15:0] o_high,
  output logic [15:0] o_period
);
  logic lvl;
  logic prev = 1'b0;
  logic [15:0] hc = 16'h0000;
  logic [15:0] pc = 16'h0000;
  // undriven pin falls to the pull-down level
  assign lvl = i_oe ? i_pin : 1'b0;
  always_ff @(posedge i_clock) begin
    prev <= lvl;
    if (lvl && !prev) begin
      o_high <= hc;
      o_period <= pc;
      hc <= 16'h0001;
      pc <= 16'h0001;
    end else begin
      hc <= hc + {15'h0000, lvl};
      pc <= pc + 16'h0001;
    end
  end
endmodule

// *** dv/tb.sv ***
// testbench for the ten-bit pwm channel
`timescale 1ns/100ps
module tb;
  import pwm_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_pin_direction_bit = 1'b0;
  logic [7:0] o_rdata;
  logic o_channel_output_pin;
  logic o_channel_output_oe;
  logic [15:0] hi_t;
  logic [15:0] per_t;
  int n_errors = 0;
  int checks = 0;
  always #20 i_clock = ~i_clock;
  pwm_channel i_pwm_channel (.i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_pin_direction_bit, .o_rdata, .o_channel_output_pin, .o_channel_output_oe);
  pwm_load i_pwm_load (.i_clock(i_clock), .i_pin(o_channel_output_pin), .i_oe(o_channel_output_oe),
    .o_high(hi_t), .o_period(per_t));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk({8'h00, o_rdata}, {8'h00, exp});
    @(posedge i_clock);
  endtask
  task automatic meas(input int cyc, input logic [15:0] h, input logic [15:0] p);
    repeat (cyc) @(posedge i_clock);
    #1 chk(hi_t, h);
    chk(per_t, p);
    @(posedge i_clock);
  endtask
  // a new duty only applies from the next period start, so let two periods pass
  task automatic hold(input logic v);
    repeat (40) @(posedge i_clock);
    repeat (40) begin
      @(posedge i_clock);
      #1 chk({15'h0000, o_channel_output_pin}, {15'h0000, v});
    end
    @(posedge i_clock);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    rd(ADDR_CONTROL, RST_BYTE);
    rd(ADDR_LIMIT_A, RST_LIMIT);
    rd(4'hF, 8'h00);
    $display("reset test done");
    wr(ADDR_LIMIT_A, 8'h03);
    wr(ADDR_DUTY_LOW, 8'h02);
    wr(ADDR_CONTROL, 8'h1C);
    // postscaler bits set on purpose, period must follow the prescaler alone
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_TIMER_CTRL_A, 8'h7C | 8'(k));
      meas(50 << (2 * k), 16'h0009 << (2 * k), 16'h0010 << (2 * k));
    end
    $display("period test done");
    wr(ADDR_TIMER_CTRL_A, 8'h04);
    wr(ADDR_DUTY_LOW, 8'h20);
    hold(1'b1);
    wr(ADDR_DUTY_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h0C);
    hold(1'b0);
    $display("duty limit test done");
    wr(ADDR_LIMIT_B, 8'h01);
    wr(ADDR_TIMER_CTRL_B, 8'h04);
    wr(ADDR_DUTY_LOW, 8'h01);
    wr(ADDR_TIMEBASE_SEL, 8'h08);
    meas(40, 16'h0004, 16'h0008);
    wr(ADDR_DUTY_ACTIVE, 8'hAA);
    rd(ADDR_DUTY_ACTIVE, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    hold(1'b0);
    i_pin_direction_bit <= 1'b1;
    @(posedge i_clock);
    #1 chk({15'h0000, o_channel_output_oe}, 16'h0000);
    $display("select test done");
    final_report;
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    final_report;
  end
endmodule
